// ---- utdds_defs.vh ----
/*
 * Constants for the transmit descriptor DMA state block: descriptor word
 * offsets, control word three field positions and widths.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef UTDDS_DEFS_VH
`define UTDDS_DEFS_VH

// Byte offsets of the four descriptor words from the descriptor address.
`define UTDDS_W0_OFS 32'h00000000
`define UTDDS_W1_OFS 32'h00000004
`define UTDDS_W2_OFS 32'h00000008
`define UTDDS_W3_OFS 32'h0000000c

// Control word three bit positions.
`define UTDDS_FIRST_BIT 31
`define UTDDS_LAST_BIT 30
`define UTDDS_OWN_BIT 29
`define UTDDS_EOQ_BIT 28
`define UTDDS_ZLP_BIT 23
`define UTDDS_PLEN_HI 15
`define UTDDS_PLEN_LO 0

// Word two fields: leading skip count and valid byte count.
`define UTDDS_SKIP_HI 31
`define UTDDS_SKIP_LO 16
`define UTDDS_BLEN_HI 15
`define UTDDS_BLEN_LO 0

// Bits of word three that the engine may write back (reserved cleared).
`define UTDDS_W3_KEEP 32'hf080ffff

// Reset value of every pointer and length of the channel state.
`define UTDDS_PTR_RST 32'h00000000
`define UTDDS_LEN_RST 16'h0000

`endif

// ---- utdds_top.v ----
/*
 * Transmit descriptor interpreter and state keeper for one DMA transmit
 * channel. It walks a descriptor chain in memory, streams packet bytes
 * into an endpoint FIFO through a two-entry buffer and writes the
 * ownership and queue-end flags back. Instantiate once per channel.
 * Assumes a single-clock memory port that answers each request with a
 * one-cycle ack, and control inputs from logic on the same clock.
 */
// Behaviour
// RQ1 - Bit 31 starts a packet.
// RQ2 - Bit 30 closes a packet.
// RQ3 - Bit 29 ownership, valid on first buffer.
// RQ4 - Clear ownership after packet fully sent.
// RQ5 - Set queue-end on final descriptor of queue.
// RQ6 - Zero-byte flag sends empty packet, no data.
// RQ7 - Packet length taken from first buffer only.
// RQ8 - Truncate packet at length, drop rest.
// RQ9 - Software never sets length above buffer total.
// RQ10 - Any buffer count per packet handled.
// RQ11 - Channel state pointers and lengths readable.
// RQ12 - One queue, one head, one completion pointer.
// RQ13 - Zero next pointer stops descriptor fetching.
// RQ14 - Skip leading bytes, count valid bytes.
// RQ15 - Completion write raises interrupt until matched.
// RQ16 - Reserved bits ignored and written as zero.
`timescale 1ns/10ps
`default_nettype none
`include "utdds_defs.vh"

module utdds_top (
    // Clock and reset.
    input wire ref_clk_i,
    input wire arst_n_i,
    // Software control of the channel state.
    input wire dma_en_i,
    input wire head_wr_i,
    input wire [31:0] head_wdata_i,
    input wire comp_wr_i,
    input wire [31:0] comp_wdata_i,
    // Readable channel state.
    output reg [31:0] tx_queue_head_ptr_o,
    output reg [31:0] tx_completion_ptr_o,
    output reg [31:0] tx_first_desc_ptr_o,
    output reg [31:0] tx_current_desc_ptr_o,
    output reg [31:0] tx_current_buf_ptr_o,
    output reg [31:0] tx_scratch_state_o,
    output reg [31:0] tx_packet_length_state_o,
    output reg chan_irq_o,
    // Memory master port.
    output reg mem_req_o,
    output reg mem_we_o,
    output reg [31:0] mem_addr_o,
    output reg [31:0] mem_wdata_o,
    input wire mem_ack_i,
    input wire [31:0] mem_rdata_i,
    // Endpoint FIFO byte stream.
    output reg [7:0] ep_data_o,
    output reg ep_last_o,
    output reg ep_zlp_o,
    output reg ep_valid_o,
    input wire ep_ready_i
);

    // Walker states.
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_RD = 3'd1;
    localparam [2:0] ST_DEC = 3'd2;
    localparam [2:0] ST_DAT = 3'd3;
    localparam [2:0] ST_FIN = 3'd4;
    localparam [2:0] ST_WBF = 3'd5;
    localparam [2:0] ST_WBE = 3'd6;
    localparam [2:0] ST_DONE = 3'd7;

    reg [2:0] st; // Walker state.
    reg [1:0] widx; // Descriptor word being fetched.
    reg [31:0] desc [0:3]; // Current descriptor words.
    reg [31:0] first_w3; // Word three of the packet's first descriptor.
    reg [15:0] rem_len; // Remaining packet bytes.
    reg [15:0] act_len; // Bytes sent so far in the packet.
    reg [15:0] buf_left; // Valid bytes left in the current buffer.
    reg [31:0] hw_comp; // Address the engine last wrote as completed.
    reg [9:0] spare; // Second buffer entry {zlp, last, byte}.
    reg spare_v; // Second entry holds a word.
    // Picks one byte of a little-endian word by its byte lane.
    function [7:0] byte_sel;
        input [31:0] w;
        input [1:0] lane;
        begin
            case (lane)
                2'd0: byte_sel = w[7:0];
                2'd1: byte_sel = w[15:8];
                2'd2: byte_sel = w[23:16];
                default: byte_sel = w[31:24];
            endcase
        end
    endfunction
    // Word three with reserved bits forced to zero for write-back.
    function [31:0] w3_clean;
        input [31:0] w;
        begin
            w3_clean = w & `UTDDS_W3_KEEP; // RQ16
        end
    endfunction
    wire [31:0] w0 = desc[0];
    wire [31:0] w3 = desc[3];
    wire is_first = w3[`UTDDS_FIRST_BIT]; // RQ1
    wire is_last = w3[`UTDDS_LAST_BIT]; // RQ2
    wire is_zlp = w3[`UTDDS_ZLP_BIT];
    wire queue_end = (w0 == `UTDDS_PTR_RST); // RQ13
    wire buf_rdy = ~spare_v; // Room for one more word.
    wire mem_done = mem_req_o & mem_ack_i;
    // Leading skip applies only on a first buffer.
    wire [15:0] skip = is_first ?
        desc[2][`UTDDS_SKIP_HI:`UTDDS_SKIP_LO] : `UTDDS_LEN_RST; // RQ14
    // Push into the buffer: a fetched data byte or a zero-length marker.
    reg push;
    reg [9:0] push_d;
    always @* begin
        push = 1'b0;
        push_d = 10'h000;
        if (st == ST_DAT && mem_done && !mem_we_o) begin
            push = 1'b1;
            // The byte closes the packet at the length or the last byte.
            push_d = {1'b0,
                (rem_len == 16'h0001) | (is_last & (buf_left == 16'h0001)),
                byte_sel(mem_rdata_i, tx_current_buf_ptr_o[1:0])};
        end else if (st == ST_DEC && is_zlp && buf_rdy) begin
            push = 1'b1;
            push_d = {1'b1, 1'b1, 8'h00}; // RQ6
        end
    end
    // Two-entry buffer; the front entry drives the ports directly so a
    // stall by the endpoint never drops a byte already fetched.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ep_valid_o <= 1'b0;
            ep_data_o <= 8'h00;
            ep_last_o <= 1'b0;
            ep_zlp_o <= 1'b0;
            spare <= 10'h000;
            spare_v <= 1'b0;
        end else if (!ep_valid_o || ep_ready_i) begin
            // Front entry frees up: refill from spare, else from push.
            if (spare_v) begin
                {ep_zlp_o, ep_last_o, ep_data_o} <= spare;
                ep_valid_o <= 1'b1;
                spare_v <= 1'b0;
            end else begin
                {ep_zlp_o, ep_last_o, ep_data_o} <= push_d;
                ep_valid_o <= push;
            end
        end else if (push) begin
            // Front is stalled; park the new word in the spare entry.
            spare <= push_d;
            spare_v <= 1'b1;
        end
    end
    // Descriptor walker, memory port and channel state.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= ST_IDLE;
            widx <= 2'd0;
            desc[0] <= `UTDDS_PTR_RST;
            desc[1] <= `UTDDS_PTR_RST;
            desc[2] <= `UTDDS_PTR_RST;
            desc[3] <= `UTDDS_PTR_RST;
            first_w3 <= `UTDDS_PTR_RST;
            rem_len <= `UTDDS_LEN_RST;
            act_len <= `UTDDS_LEN_RST;
            buf_left <= `UTDDS_LEN_RST;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= `UTDDS_PTR_RST;
            mem_wdata_o <= `UTDDS_PTR_RST;
            tx_queue_head_ptr_o <= `UTDDS_PTR_RST;
            tx_first_desc_ptr_o <= `UTDDS_PTR_RST;
            tx_current_desc_ptr_o <= `UTDDS_PTR_RST;
            tx_current_buf_ptr_o <= `UTDDS_PTR_RST;
        end else begin
            // Software may reload the head only while the walker rests,
            // so a busy chain is never redirected midway.
            if (head_wr_i && st == ST_IDLE) begin
                tx_queue_head_ptr_o <= head_wdata_i; // RQ12
            end
            case (st)
                ST_IDLE: begin
                    if (dma_en_i && tx_queue_head_ptr_o != `UTDDS_PTR_RST &&
                        !head_wr_i) begin
                        tx_current_desc_ptr_o <= tx_queue_head_ptr_o;
                        st <= ST_RD;
                    end
                end
                ST_RD: begin
                    // Fetch the four descriptor words in order.
                    if (!mem_req_o) begin
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b0;
                        mem_addr_o <= tx_current_desc_ptr_o + {widx, 2'b00};
                    end else if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        desc[widx] <= mem_rdata_i;
                        widx <= widx + 2'd1;
                        if (widx == 2'd3) begin
                            st <= ST_DEC;
                        end
                    end
                end
                ST_DEC: begin
                    if (is_first) begin
                        // A new packet: length and ownership come from here.
                        tx_first_desc_ptr_o <= tx_current_desc_ptr_o; // RQ1
                        first_w3 <= w3; // RQ3
                        rem_len <= w3[`UTDDS_PLEN_HI:`UTDDS_PLEN_LO]; // RQ7
                        act_len <= `UTDDS_LEN_RST;
                    end
                    tx_current_buf_ptr_o <= desc[1] + {16'h0000, skip}; // RQ14
                    buf_left <= desc[2][`UTDDS_BLEN_HI:`UTDDS_BLEN_LO]; // RQ14
                    if (!is_zlp) begin
                        st <= ST_DAT;
                    end else if (buf_rdy) begin
                        st <= ST_FIN; // RQ6
                    end
                end
                ST_DAT: begin
                    if (!mem_req_o) begin
                        // Stop at buffer end or at the packet length; any
                        // bytes beyond the length are simply not read.
                        if (buf_left == `UTDDS_LEN_RST ||
                            rem_len == `UTDDS_LEN_RST) begin
                            st <= ST_FIN; // RQ8
                        end else if (buf_rdy) begin
                            mem_req_o <= 1'b1;
                            mem_we_o <= 1'b0;
                            mem_addr_o <= {tx_current_buf_ptr_o[31:2], 2'b00};
                        end
                    end else if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        rem_len <= rem_len - 16'h0001;
                        act_len <= act_len + 16'h0001;
                        buf_left <= buf_left - 16'h0001;
                        tx_current_buf_ptr_o <= tx_current_buf_ptr_o + 32'h1;
                    end
                end
                ST_FIN: begin
                    // Middle and first buffers chain on unless the next pointer is zero; last ones close.
                    if (is_last) begin
                        st <= ST_WBF; // RQ10
                    end else if (queue_end) begin
                        tx_queue_head_ptr_o <= `UTDDS_PTR_RST; // RQ13
                        st <= ST_IDLE;
                    end else begin
                        tx_current_desc_ptr_o <= w0; // RQ10
                        st <= ST_RD;
                    end
                end
                ST_WBF: begin
                    // Hand the packet back by clearing ownership; when the
                    // first descriptor is also the queue's last one the
                    // queue-end flag goes out in the same write.
                    if (!mem_req_o) begin
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b1;
                        mem_addr_o <= tx_first_desc_ptr_o + `UTDDS_W3_OFS;
                        mem_wdata_o <= (w3_clean(first_w3) &
                            ~(32'h1 << `UTDDS_OWN_BIT)) |
                            ({31'h0, queue_end & (tx_first_desc_ptr_o ==
                            tx_current_desc_ptr_o)} << `UTDDS_EOQ_BIT); // RQ4
                    end else if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o <= 1'b0;
                        if (queue_end &&
                            tx_first_desc_ptr_o != tx_current_desc_ptr_o) begin
                            st <= ST_WBE;
                        end else begin
                            st <= ST_DONE;
                        end
                    end
                end
                ST_WBE: begin
                    // Mark the final descriptor of the final packet.
                    if (!mem_req_o) begin
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b1;
                        mem_addr_o <= tx_current_desc_ptr_o + `UTDDS_W3_OFS;
                        mem_wdata_o <= w3_clean(w3) |
                            (32'h1 << `UTDDS_EOQ_BIT); // RQ5
                    end else if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o <= 1'b0;
                        st <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Advance the head; a zero head leaves the queue empty.
                    // The word index wraps to zero after each four-word descriptor fetch.
                    tx_queue_head_ptr_o <= w0; // RQ13
                    if (queue_end) begin
                        st <= ST_IDLE;
                    end else begin
                        tx_current_desc_ptr_o <= w0;
                        st <= ST_RD;
                    end
                end
                default: begin
                    st <= ST_IDLE;
                end
            endcase
        end
    end
    // Completion pointer and channel interrupt. The engine's own write
    // wins a tie with software, and a raise beats a same-cycle clear.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_completion_ptr_o <= `UTDDS_PTR_RST;
            hw_comp <= `UTDDS_PTR_RST;
            chan_irq_o <= 1'b0;
        end else if (st == ST_DONE) begin
            tx_completion_ptr_o <= tx_current_desc_ptr_o; // RQ15
            hw_comp <= tx_current_desc_ptr_o;
            chan_irq_o <= 1'b1; // RQ15
        end else if (comp_wr_i) begin
            tx_completion_ptr_o <= comp_wdata_i;
            // Only an exact echo of the engine's address acknowledges.
            if (comp_wdata_i == hw_comp) begin
                chan_irq_o <= 1'b0; // RQ15
            end
        end
    end
    // Length and scratch state, registered for software reads.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_packet_length_state_o <= `UTDDS_PTR_RST;
            tx_scratch_state_o <= `UTDDS_PTR_RST;
        end else begin
            tx_packet_length_state_o <= {rem_len, act_len}; // RQ11
            tx_scratch_state_o <= {10'h000, spare_v, widx, st, buf_left};
        end
    end

endmodule
`default_nettype wire

// ---- utdds_mem_model.sv ----
/* Memory partner for the transmit descriptor walker: a word array with a
   one-cycle ack after a stall chosen by the bench.
   Assumes the walker holds its request steady until the ack edge. */
`timescale 1ns/10ps
`default_nettype none
module utdds_mem_model (
    // Clock, reset and stall control.
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic stall_i,
    // Walker memory port.
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    output logic mem_ack_o,
    output logic [31:0] mem_rdata_o
);
    // Descriptors and buffers live in the low kilobyte.
    logic [31:0] mem [0:255];
    // Read data toggles when not answering, so late sampling is caught.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 32'h00000000;
        end else if (mem_ack_o) begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            if (mem_we_i) begin
                mem[mem_addr_i[9:2]] <= mem_wdata_i;
            end
        end else if (mem_req_i && !stall_i) begin
            mem_ack_o <= 1'b1;
            mem_rdata_o <= mem[mem_addr_i[9:2]];
        end else begin
            mem_rdata_o <= ~mem_rdata_o;
        end
    end
endmodule
`default_nettype wire

// ---- utdds_checker.sv ----
/* Port-level assertions for the transmit descriptor block.
   Assumes it is bound into utdds_top and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module utdds_checker (
    // Clock, reset and software ack.
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic comp_wr_i,
    input wire logic chan_irq_o,
    // Memory port.
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic [31:0] mem_wdata_o,
    input wire logic mem_ack_i,
    // Endpoint stream.
    input wire logic [7:0] ep_data_o,
    input wire logic ep_last_o,
    input wire logic ep_zlp_o,
    input wire logic ep_valid_o,
    input wire logic ep_ready_i
);
    // One clock domain; nothing is judged while reset is low.
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    zlp_form_a:
        assert property (ep_valid_o && ep_zlp_o |-> ep_last_o && !ep_data_o)
        else $error("zero-length entry malformed");
    ep_hold_a:
        assert property (ep_valid_o && !ep_ready_i |=> ep_valid_o
            && $stable(ep_data_o) && $stable(ep_last_o))
        else $error("stalled entry changed");
    req_hold_a:
        assert property (mem_req_o && !mem_ack_i |=> mem_req_o
            && $stable(mem_addr_o) && $stable(mem_we_o))
        else $error("memory request not held");
    req_drop_a:
        assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
        else $error("memory request not dropped");
    read_align_a:
        assert property (mem_req_o |-> mem_addr_o[1:0] == 2'b00)
        else $error("unaligned memory access");
    wb_rsvd_a:
        assert property (mem_req_o && mem_we_o |-> mem_addr_o[3:0] == 4'hc
            && (mem_wdata_o & 32'h0f7f0000) == 32'h00000000)
        else $error("bad write-back");
    wb_own_a:
        assert property (mem_req_o && mem_we_o |-> !mem_wdata_o[29])
        else $error("ownership left set");
    irq_keep_a:
        assert property (chan_irq_o && !comp_wr_i |=> chan_irq_o)
        else $error("interrupt dropped without ack");
    irq_fall_a:
        assert property ($fell(chan_irq_o) |-> $past(comp_wr_i))
        else $error("interrupt fell without write");
endmodule
bind utdds_top utdds_checker chk (.ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i), .comp_wr_i(comp_wr_i), .chan_irq_o(chan_irq_o),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
    .ep_data_o(ep_data_o), .ep_last_o(ep_last_o), .ep_zlp_o(ep_zlp_o),
    .ep_valid_o(ep_valid_o), .ep_ready_i(ep_ready_i));
`default_nettype wire

// ---- utdds_top_tb.sv ----
/* Self-checking bench for utdds_top: expected bytes and write-backs are
   worked out from the descriptors placed in the memory partner.
   Assumes utdds_mem_model and utdds_checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module utdds_top_tb;
    logic ref_clk_i, arst_n_i, dma_en_i, head_wr_i, comp_wr_i;
    logic [31:0] head_wdata_i, comp_wdata_i, head_p, comp_p, first_p;
    logic [31:0] cur_p, buf_p, len_p, addr, wdata, rdata;
    logic [31:0] scr_p, exp_len, exp_buf; // Scratch state read back; expected end-of-packet state.
    logic irq, req, we, ack, ep_last, ep_zlp, ep_valid, ep_ready, stall;
    logic rdy; // Ready level the endpoint shows at the next rising edge.
    logic [7:0] ep_data;
    logic [9:0] exp_q[$]; // Expected {zlp, last, byte} entries.
    integer seed, err_count, checks_done;
    utdds_top dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .dma_en_i(dma_en_i), .head_wr_i(head_wr_i),
        .head_wdata_i(head_wdata_i), .comp_wr_i(comp_wr_i),
        .comp_wdata_i(comp_wdata_i), .tx_queue_head_ptr_o(head_p),
        .tx_completion_ptr_o(comp_p), .tx_first_desc_ptr_o(first_p),
        .tx_current_desc_ptr_o(cur_p), .tx_current_buf_ptr_o(buf_p),
        .tx_scratch_state_o(scr_p), .tx_packet_length_state_o(len_p),
        .chan_irq_o(irq), .mem_req_o(req), .mem_we_o(we),
        .mem_addr_o(addr), .mem_wdata_o(wdata), .mem_ack_i(ack),
        .mem_rdata_i(rdata), .ep_data_o(ep_data), .ep_last_o(ep_last),
        .ep_zlp_o(ep_zlp), .ep_valid_o(ep_valid), .ep_ready_i(ep_ready));
    utdds_mem_model mem_m (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .stall_i(stall), .mem_req_i(req), .mem_we_i(we),
        .mem_addr_i(addr), .mem_wdata_i(wdata), .mem_ack_o(ack),
        .mem_rdata_o(rdata));
    // Free-running 100 MHz clock.
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // Counts a comparison and reports a mismatch at once.
    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, want);
        end
    endtask
    // Reads one byte of the partner's memory.
    function automatic logic [7:0] mbyte(input logic [31:0] a);
        logic [31:0] w;
        w = mem_m.mem[a[9:2]] >> {a[1:0], 3'b000};
        return w[7:0];
    endfunction
    // Writes the four words of one descriptor.
    task automatic put_desc(input logic [31:0] a, nx, bp, w2, w3);
        mem_m.mem[a[9:2]] = nx;
        mem_m.mem[a[9:2] + 8'd1] = bp;
        mem_m.mem[a[9:2] + 8'd2] = w2;
        mem_m.mem[a[9:2] + 8'd3] = w3;
    endtask
    // Walks one packet's chain and queues the entries it must produce.
    task automatic expect_pkt(input logic [31:0] d);
        logic [31:0] w2, w3, bp;
        logic lastb;
        int rem, skip, n, sent;
        rem = 0;
        sent = 0;
        skip = -1;
        forever begin
            bp = mem_m.mem[d[9:2] + 8'd1];
            w2 = mem_m.mem[d[9:2] + 8'd2];
            w3 = mem_m.mem[d[9:2] + 8'd3];
            if (skip < 0) begin
                rem = w3[15:0];
            end
            skip = (skip < 0) ? w2[31:16] : 0;
            n = 0;
            if (w3[23]) begin
                exp_q.push_back(10'h300);
            end else begin
                for (n = 0; n < w2[15:0] && rem > 0; n++) begin
                    rem--;
                    sent++;
                    lastb = rem == 0 || (w3[30] && n == w2[15:0] - 1);
                    exp_q.push_back({1'b0, lastb, mbyte(bp + skip + n)});
                end
            end
            // The buffer pointer rests just past the last byte read.
            exp_buf = bp + skip + n;
            if (w3[30]) break;
            d = mem_m.mem[d[9:2]];
        end
        // Remaining length in the top half, bytes sent in the bottom.
        exp_len = {rem[15:0], sent[15:0]};
    endtask
    // Starts one queue, waits for completion, checks and acknowledges it.
    task automatic run_pkt(input logic [31:0] fd, ld);
        int t;
        expect_pkt(fd);
        head_wdata_i = fd;
        head_wr_i = 1'b1;
        @(negedge ref_clk_i);
        head_wr_i = 1'b0;
        for (t = 0; t < 3000 && irq !== 1'b1; t++) @(negedge ref_clk_i);
        cmp(irq, 1);
        cmp(comp_p, ld);
        cmp(first_p, fd);
        cmp(cur_p, ld);
        cmp(buf_p, exp_buf);
        cmp(len_p, exp_len);
        cmp(mem_m.mem[fd[9:2] + 8'd3] & 32'h2f7f0000, 0);
        cmp(mem_m.mem[ld[9:2] + 8'd3] & 32'h1f7f0000, 32'h10000000);
        comp_wdata_i = ld ^ 32'h00000010;
        comp_wr_i = 1'b1;
        @(negedge ref_clk_i);
        comp_wr_i = 1'b0;
        @(negedge ref_clk_i);
        cmp(irq, 1);
        comp_wdata_i = ld;
        comp_wr_i = 1'b1;
        @(negedge ref_clk_i);
        comp_wr_i = 1'b0;
        @(negedge ref_clk_i);
        cmp(irq, 0);
        for (t = 0; t < 100 && exp_q.size() != 0; t++) @(negedge ref_clk_i);
        cmp(exp_q.size(), 0);
        cmp(scr_p[31:16], 0);
        cmp(head_p, 0);
    endtask
    // Draws the ready level for the coming edge first, so that the entry
    // shown now is checked against the ready that will take it.
    always @(negedge ref_clk_i) begin
        rdy = ($random(seed) & 3) != 0;
        if (arst_n_i && ep_valid && rdy) begin
            cmp(exp_q.size() > 0, 1);
            if (exp_q.size() > 0) begin
                cmp({ep_zlp, ep_last, ep_data}, exp_q.pop_front());
            end
        end
        ep_ready <= rdy;
        stall <= ($random(seed) & 3) == 0;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog: far beyond the few hundred cycles the queues need.
    initial begin
        #200000;
        err_count++;
        wrap_up;
    end
    // Main sequence: reset, then three queues of different shapes.
    initial begin
        seed = 32'hdad37ea1;
        {dma_en_i, head_wr_i, comp_wr_i, ep_ready, stall} = 5'b10000;
        head_wdata_i = 32'h00000000;
        comp_wdata_i = 32'h00000000;
        err_count = 0;
        checks_done = 0;
        arst_n_i = 1'b0;
        for (int i = 128; i < 192; i++) mem_m.mem[i] = $random(seed);
        // Single buffer, offset 1, cut from 5 to 3, junk reserved bits.
        put_desc(32'h100, 0, 32'h201, 32'h00010005, 32'hea550003);
        // Three buffers: first only, neither, last only; 7 bytes in all.
        put_desc(32'h110, 32'h120, 32'h240, 2, 32'ha0000007);
        put_desc(32'h120, 32'h130, 32'h250, 3, 0);
        put_desc(32'h130, 0, 32'h263, 2, 32'h40000000);
        // Zero-byte packet whose buffer must not be read.
        put_desc(32'h140, 0, 32'h280, 4, 32'he0800000);
        repeat (4) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        cmp(head_p | comp_p | first_p | cur_p | buf_p | len_p, 0);
        @(negedge ref_clk_i);
        run_pkt(32'h100, 32'h100);
        run_pkt(32'h110, 32'h130);
        run_pkt(32'h140, 32'h140);
        wrap_up;
    end
endmodule
`default_nettype wire
